/* core/qpipe_core.sv */
// Four-phase fetch/execute sequencer with return-address stack
`timescale 1ns/1ps
module qpipe_core (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Program memory
    output logic [qpipe_pkg::PTR_W-1:0] PMEM_ADDR,
    output logic PMEM_RD,
    input wire logic [qpipe_pkg::WORD_W-1:0] PMEM_RDATA,
    // Data memory
    output qpipe_pkg::dmem_req_s DMEM_REQ,
    input wire logic [qpipe_pkg::DATA_W-1:0] DMEM_RDATA,
    // Execute unit
    output logic [qpipe_pkg::WORD_W-1:0] EXEC_WORD,
    output logic EXEC_VALID,
    output qpipe_pkg::phase_e PHASE,
    output logic [qpipe_pkg::DATA_W-1:0] EXEC_OPERAND,
    input wire logic [qpipe_pkg::DADDR_W-1:0] EXEC_DADDR,
    input wire logic EXEC_DRD,
    input wire logic EXEC_DWR,
    input wire logic [qpipe_pkg::DATA_W-1:0] EXEC_RESULT,
    input wire qpipe_pkg::flow_s EXEC_FLOW,
    // Status
    output logic [qpipe_pkg::PTR_W-1:0] INSTRUCTION_POINTER,
    output logic STACK_OVERFLOW
);
    import qpipe_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    core_state_s state;
    core_state_s next_state;
    logic stack_we;
    logic [STACK_AW-1:0] stack_waddr;
    logic [STACK_AW-1:0] stack_raddr;
    logic [PTR_W-1:0] stack_top;
    logic [PTR_W-1:0] return_ptr;

    // ----------------------------------------
    // Return-address stack
    // ----------------------------------------
    qpipe_stack #(
        .DEPTH(STACK_DEPTH),
        .AW(STACK_AW),
        .W(PTR_W)
    ) u_stack (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .we(stack_we),
        .waddr(stack_waddr),
        .wdata(return_ptr),
        .raddr(stack_raddr),
        .rdata(stack_top)
    );

    // The pointer runs one ahead of the word fetched behind the call, so the
    // fetch address is saved; saving the pointer would skip that word
    assign return_ptr = state.pointer - 13'h0001;
    // Count holds at full; overflow is flagged and each push then overwrites slot 0, which first held the oldest entry
    assign stack_waddr = state.stack_cnt[STACK_AW-1:0];
    assign stack_raddr = state.stack_cnt[STACK_AW-1:0] - 3'h1;
    // Push lands at the end of the execution cycle so the read register
    // always shows the current top by the next phase four
    assign stack_we = state.exec_valid && state.phase == PH_FOUR
        && EXEC_FLOW.kind == FLOW_CALL;

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.dmem = '0;
        unique case (state.phase)
            PH_ONE:
            begin
                next_state.phase = PH_TWO;
                // Prefetched word enters the holding register, or an idle slot
                next_state.instruction_holding_register =
                    state.flush ? IDLE_WORD : state.fetch_word;
                next_state.exec_valid = !state.flush;
                next_state.flush = 1'b0;
                next_state.pointer = state.pointer + 13'h0001;
            end
            PH_TWO:
            begin
                next_state.phase = PH_THREE;
                // Operand read issued at the start of phase three
                next_state.dmem.rd = state.exec_valid && EXEC_DRD;
                next_state.dmem.addr = EXEC_DADDR;
            end
            PH_THREE:
            begin
                next_state.phase = PH_FOUR;
                if (state.dmem.rd)
                begin
                    next_state.operand = DMEM_RDATA;
                end
            end
            PH_FOUR:
            begin
                next_state.phase = PH_ONE;
                next_state.fetch_word = PMEM_RDATA;
                next_state.dmem.wr = state.exec_valid && EXEC_DWR;
                next_state.dmem.addr = EXEC_DADDR;
                next_state.dmem.wdata = EXEC_RESULT;
                if (state.exec_valid && EXEC_FLOW.kind != FLOW_NONE)
                begin
                    // Next cycle runs idle while the target is fetched
                    next_state.flush = 1'b1;
                    unique case (EXEC_FLOW.kind)
                        FLOW_RETURN:
                        begin
                            next_state.pointer = stack_top;
                            next_state.stack_cnt = state.stack_cnt - 4'h1;
                        end
                        FLOW_CALL:
                        begin
                            next_state.pointer = EXEC_FLOW.target;
                            if (state.stack_cnt == 4'(STACK_DEPTH))
                            begin
                                next_state.stack_overflow = 1'b1;
                            end
                            else
                            begin
                                next_state.stack_cnt = state.stack_cnt + 4'h1;
                            end
                        end
                        default:
                        begin
                            next_state.pointer = EXEC_FLOW.target;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state.phase <= PH_ONE;
            state.pointer <= PTR_RESET;
            state.fetch_word <= IDLE_WORD;
            state.instruction_holding_register <= IDLE_WORD;
            state.exec_valid <= 1'b0;
            state.flush <= 1'b1;
            state.stack_cnt <= STACK_CNT_RESET;
            state.stack_overflow <= 1'b0;
            state.operand <= '0;
            state.dmem <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Program memory is addressed for the whole fetch cycle; word taken in phase four
    assign PMEM_ADDR = state.pointer - 13'h0001;
    assign PMEM_RD = state.phase == PH_FOUR;
    assign DMEM_REQ = state.dmem;
    assign EXEC_WORD = state.instruction_holding_register;
    assign EXEC_VALID = state.exec_valid;
    assign PHASE = state.phase;
    assign EXEC_OPERAND = state.operand;
    assign INSTRUCTION_POINTER = state.pointer;
    assign STACK_OVERFLOW = state.stack_overflow;
endmodule

/* include/qpipe_pkg.sv */
// Package: constants and carriers for the four-phase fetch/execute sequencer
package qpipe_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int PTR_W = 13;
    localparam int WORD_W = 14;
    localparam int DADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_AW = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [PTR_W-1:0] PTR_RESET = 13'h0000;
    localparam logic [WORD_W-1:0] IDLE_WORD = 14'h0000;
    localparam logic [STACK_AW:0] STACK_CNT_RESET = 4'h0;

    // Phase sequence, Gray coded along the loop
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b11,
        PH_FOUR = 2'b10
    } phase_e;

    // Flow-change request from the execute unit
    typedef enum logic [1:0] {
        FLOW_NONE = 2'b00,
        FLOW_JUMP = 2'b01,
        FLOW_CALL = 2'b10,
        FLOW_RETURN = 2'b11
    } flow_e;

    typedef struct packed {
        flow_e kind;
        logic [PTR_W-1:0] target;
    } flow_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dmem_req_s;

    typedef struct packed {
        phase_e phase;
        logic [PTR_W-1:0] pointer;
        logic [WORD_W-1:0] fetch_word;
        logic [WORD_W-1:0] instruction_holding_register;
        logic exec_valid;
        logic flush;
        logic [STACK_AW:0] stack_cnt;
        logic stack_overflow;
        logic [DATA_W-1:0] operand;
        dmem_req_s dmem;
    } core_state_s;

endpackage

/* core/qpipe_stack.sv */
// Return-address stack memory with registered read data
`timescale 1ns/1ps
module qpipe_stack #(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int W = 13
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    // Storage holds no reset; only the read register is defined after reset
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end
endmodule

/* dv/qpipe_monitor.sv */
// Port checker for the four-phase sequencer
`timescale 1ns/1ps
module qpipe_monitor (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic [qpipe_pkg::PTR_W-1:0] PMEM_ADDR,
    input wire logic PMEM_RD,
    input wire qpipe_pkg::dmem_req_s DMEM_REQ,
    input wire logic [qpipe_pkg::WORD_W-1:0] EXEC_WORD,
    input wire logic EXEC_VALID,
    input wire qpipe_pkg::phase_e PHASE,
    input wire logic EXEC_DRD,
    input wire logic EXEC_DWR,
    input wire logic [qpipe_pkg::DATA_W-1:0] EXEC_RESULT,
    input wire qpipe_pkg::flow_s EXEC_FLOW,
    input wire logic [qpipe_pkg::PTR_W-1:0] INSTRUCTION_POINTER
);
    import qpipe_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    a_phase_loop:
    assert property (PHASE == PH_ONE |=> PHASE == PH_TWO ##1 PHASE == PH_THREE
        ##1 PHASE == PH_FOUR ##1 PHASE == PH_ONE) else $error("phase loop");
    a_ptr_step:
    assert property (PHASE == PH_ONE |=> INSTRUCTION_POINTER ==
        $past(INSTRUCTION_POINTER) + 13'h0001) else $error("pointer step");
    a_fetch_slot:
    assert property (PMEM_RD == (PHASE == PH_FOUR)
        && PMEM_ADDR == INSTRUCTION_POINTER - 13'h0001) else $error("fetch slot");
    a_word_hold:
    assert property (PHASE != PH_ONE |=> $stable(EXEC_WORD) && $stable(EXEC_VALID))
        else $error("word moved");
    a_strobe_phase:
    assert property ((!DMEM_REQ.rd || PHASE == PH_THREE) && (!DMEM_REQ.wr || PHASE == PH_ONE))
        else $error("strobe phase");
    a_read_slot:
    assert property (PHASE == PH_TWO && EXEC_VALID && EXEC_DRD |=> DMEM_REQ.rd)
        else $error("no read");
    a_write_slot:
    assert property (PHASE == PH_FOUR && EXEC_VALID && EXEC_DWR |=> DMEM_REQ.wr
        && DMEM_REQ.wdata == $past(EXEC_RESULT)) else $error("bad write");
    a_flow_idle:
    assert property (PHASE == PH_FOUR && EXEC_VALID && EXEC_FLOW.kind inside {FLOW_JUMP,
        FLOW_CALL} |=> INSTRUCTION_POINTER == $past(EXEC_FLOW.target)
        ##1 !EXEC_VALID [*4] ##1 EXEC_VALID) else $error("flow change");
endmodule

/* dv/qpipe_mem_model.sv */
// Program and data memory partner
`timescale 1ns/1ps
module qpipe_mem_model (
    input wire logic clk,
    input wire logic [qpipe_pkg::PTR_W-1:0] paddr,
    input wire logic prd,
    output logic [qpipe_pkg::WORD_W-1:0] pdata,
    input wire qpipe_pkg::dmem_req_s dreq,
    output logic [qpipe_pkg::DATA_W-1:0] ddata
);
    logic [7:0] mem [512];
    // Word is its own address with the top bit set; unselected buses show inverted data, never held values
    assign pdata = prd ? {1'b1, paddr} : ~{1'b1, paddr};
    assign ddata = dreq.rd ? mem[dreq.addr] : ~mem[dreq.addr];
    always @(posedge clk)
        if (dreq.wr)
            mem[dreq.addr] <= dreq.wdata;
endmodule

/* dv/tb_quad_phase_fetch_execute_pipeline.sv */
// Self-checking bench for the four-phase sequencer
`timescale 1ns/1ps
module tb_quad_phase_fetch_execute_pipeline;
    import qpipe_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [12:0] paddr, ptr, ra;
    logic prd, ev, ovf;
    logic [13:0] pdata, ew, cw;
    dmem_req_s dreq;
    logic [7:0] ddata, opnd;
    phase_e ph;
    logic drd = 1'b0;
    logic dwr = 1'b0;
    logic [8:0] da = 9'h1a5;
    logic [7:0] res = 8'h3c;
    flow_s fl = '0;
    int err_count = 0;
    int n_checks = 0;
    qpipe_core dut (.REF_CLK(clk), .ARST_N(rst_n), .PMEM_ADDR(paddr), .PMEM_RD(prd),
        .PMEM_RDATA(pdata), .DMEM_REQ(dreq), .DMEM_RDATA(ddata), .EXEC_WORD(ew),
        .EXEC_VALID(ev), .PHASE(ph), .EXEC_OPERAND(opnd), .EXEC_DADDR(da),
        .EXEC_DRD(drd), .EXEC_DWR(dwr), .EXEC_RESULT(res), .EXEC_FLOW(fl),
        .INSTRUCTION_POINTER(ptr), .STACK_OVERFLOW(ovf));
    qpipe_mem_model mem (.clk(clk), .paddr(paddr), .prd(prd), .pdata(pdata),
        .dreq(dreq), .ddata(ddata));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok)
        begin
            err_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_ph(input phase_e p, input bit v);
        int n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while ((ph !== p || (v && ev !== 1'b1)) && n < 40);
        chk(n < 40, "wait");
    endtask
    // Execute inputs count only while a real word runs
    task automatic issue(input phase_e p, input bit r, input bit w, input flow_e k,
        input logic [12:0] t);
        wait_ph(p, 1'b1);
        cw = ew;
        {drd, dwr} = {r, w};
        fl = '{k, t};
        @(negedge clk);
        {drd, dwr} = 2'b00;
        fl = '0;
    endtask
    task automatic t_walk();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            chk(ptr === 13'(1 + i / 4), "pointer");
            chk(ev === (i > 3), "idle start");
        end
        chk(ew === 14'h2000, "first word");
    endtask
    task automatic t_data();
        issue(PH_FOUR, 1'b0, 1'b1, FLOW_NONE, '0);
        ra = cw[12:0];
        // Result moves on, so the operand can only come back from memory
        res = 8'hc3;
        issue(PH_TWO, 1'b1, 1'b0, FLOW_NONE, '0);
        chk(cw[12:0] === ra + 13'h0001, "overlap");
        wait_ph(PH_FOUR, 1'b1);
        chk(opnd === 8'h3c, "operand");
    endtask
    task automatic t_flow(input flow_e k, input logic [12:0] t, input logic [12:0] e);
        issue(PH_FOUR, 1'b0, 1'b0, k, t);
        wait_ph(PH_TWO, 1'b0);
        chk(ev === 1'b0, "no idle");
        wait_ph(PH_TWO, 1'b1);
        chk(ew === {1'b1, e}, "target");
    endtask
    initial
    begin
        repeat (13) @(negedge clk);
        chk(ph === PH_ONE && paddr === 13'h1fff, "reset");
        rst_n = 1'b1;
        t_walk();
        t_data();
        t_flow(FLOW_JUMP, 13'h0a5, 13'h0a5);
        t_flow(FLOW_CALL, 13'h100, 13'h100);
        t_flow(FLOW_RETURN, 13'h000, 13'h0a6);
        for (int i = 0; i < 9; i++)
        begin
            t_flow(FLOW_CALL, 13'h040, 13'h040);
            chk(ovf === (i == 8), "overflow");
        end
        print_verdict();
    end
    initial
    begin
        #20000;
        err_count++;
        print_verdict();
    end
endmodule
bind qpipe_core qpipe_monitor mon (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .PMEM_ADDR(PMEM_ADDR), .PMEM_RD(PMEM_RD), .DMEM_REQ(DMEM_REQ), .EXEC_WORD(EXEC_WORD),
    .EXEC_VALID(EXEC_VALID), .PHASE(PHASE), .EXEC_DRD(EXEC_DRD), .EXEC_DWR(EXEC_DWR),
    .EXEC_RESULT(EXEC_RESULT), .EXEC_FLOW(EXEC_FLOW),
    .INSTRUCTION_POINTER(INSTRUCTION_POINTER));
